// file: hdl/gpb_pkg.sv
// Register map, reset values and timing constants of the GPIO bank.
// Summary of operation
// - After reset every multiplexed pin serves its native function.
// - Input status sets after two active clocks and stays until cleared.
// - Any input status can be routed to the management or event interrupt.
// - Select bit 1 with control bit 25 set moves pins to pair five.
// - Select bit 0 means native use, 1 means GPIO; reset 1A003180h.
// - Select bits without pin or without multiplexing are not implemented.
// - Direction bits 28:27 and 25:24 are writable; 0 output, 1 input.
// - Direction bits 23:16 read 0 and bits 15:0 read 1.
// - Resume outputs take default state only after standby reset release.
// - Selectable level bits drive outputs; as inputs they read pin level.
// - Resume level bits reset only on the standby well reset.
// - Level bits 23:16 reset on host bus reset; register resets 1B3F0000h.
// - Input-only pins show activity in event status, not in level.
// - A flashing output toggles every half second (one period per second) at half duty.
// - Flashing keeps the level bit and does nothing on an input.
// - Pin 18 flashes from reset; flash register resets to 00040000h.
// - Polarity 0 sets status on high pin, 1 on low pin.
// - A polarity bit has no effect while its pin is an output.
// - Polarity 7:6, 4:3, 1:0 reset on host reset; 13:11, 8 on standby.
// - Bits of nonexistent pins ignore writes and read 0, except direction bits 15:0 and driver bit 26, which read 1.
package gpb_pkg;
  localparam int PINS = 32;
  localparam int INS = 16;
  localparam int AW = 6;
  // ==========================================================================
  // Register offsets.
  localparam logic [5:0] OFF_FSEL = 6'h00;
  localparam logic [5:0] OFF_DIR = 6'h04;
  localparam logic [5:0] OFF_LVL = 6'h0C;
  localparam logic [5:0] OFF_DRV = 6'h14;
  localparam logic [5:0] OFF_FLASH = 6'h18;
  localparam logic [5:0] OFF_POL = 6'h2C;
  // ==========================================================================
  // Reset values and field masks.
  localparam logic [31:0] FSEL_RESET = 32'h1A003180;
  localparam logic [31:0] FSEL_IMPL = 32'h0020081B;
  localparam logic [31:0] FSEL_CORE = 32'h0020001B;
  localparam logic [31:0] DIR_RESET = 32'h0000FFFF;
  localparam logic [31:0] DIR_WR = 32'h1B000000;
  localparam logic [31:0] LVL_RESET = 32'h1B3F0000;
  localparam logic [31:0] LVL_CORE = 32'h00FF0000;
  localparam logic [31:0] LVL_RES = 32'h1B000000;
  localparam logic [31:0] DRV_RESET = 32'h06630000;
  localparam logic [31:0] FLASH_RESET = 32'h00040000;
  localparam logic [31:0] FLASH_IMPL = 32'h1A0C0000;
  localparam logic [31:0] FLASH_CORE = 32'h000C0000;
  localparam logic [31:0] POL_RESET = 32'h00000000;
  localparam logic [31:0] POL_IMPL = 32'h000039DB;
  localparam logic [31:0] POL_CORE = 32'h000000DB;
  localparam logic [15:0] IN_IMPL = 16'h39DB;
  localparam logic [15:0] STAT_CORE = 16'h00DB;
  localparam logic [31:0] PIN_EXIST = 32'h1BFF39DB;
  localparam int PAIR_SEL_BIT = 1;
  // ==========================================================================
  // Timing.
  localparam int ACTIVE_CLOCKS = 2;
  localparam int CLK_HZ = 50_000_000;
  localparam int FLASH_HALF_MS = 500;
  localparam int FLASH_HALF_CYCLES = CLK_HZ / 1000 * FLASH_HALF_MS;
endpackage

// file: hdl/gpb_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous levels.
module gpb_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  import gpb_pkg::*;
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gpb_sync_type;
  gpb_sync_type s;
  gpb_sync_type next_s;

  // The first stage feeds only the second stage.
  always_comb begin
    next_s.s1 = d_in;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_out = s.s2;
endmodule

// file: hdl/gpb_flash.sv
// Free-running divider that gives the common flash phase.
module gpb_flash #(
  parameter int HALF_CYCLES = 25_000_000
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  output logic phase_out
);
  import gpb_pkg::*;
  localparam int CW = $clog2(HALF_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic phase;
  } gpb_flash_type;
  gpb_flash_type s;
  gpb_flash_type next_s;

  // Equal high and low halves give the half duty cycle.
  always_comb begin
    next_s = s;
    if (s.cnt == LAST) begin
      next_s.cnt = '0;
      next_s.phase = ~s.phase;
    end else begin
      next_s.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign phase_out = s.phase;
endmodule

// file: hdl/gpb_bank.sv
// GPIO bank: register window, pin drive, flashing and input event status.
module gpb_bank #(
  parameter int FLASH_HALF_CYCLES = gpb_pkg::FLASH_HALF_CYCLES
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic host_bus_reset_n_in,
  input wire logic [gpb_pkg::AW-1:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [3:0] io_byte_en_in,
  input wire logic [31:0] io_wdata_in,
  output logic [31:0] io_rdata_out,
  output logic io_rvalid_out,
  input wire logic [gpb_pkg::PINS-1:0] pin_in,
  output logic [gpb_pkg::PINS-1:0] pin_out,
  output logic [gpb_pkg::PINS-1:0] pin_oe_out,
  input wire logic [gpb_pkg::PINS-1:0] native_out_in,
  input wire logic [gpb_pkg::PINS-1:0] native_oe_in,
  input wire logic general_control_bit25_in,
  output logic req_pair2_en_out,
  output logic req_pair5_en_out,
  input wire logic [gpb_pkg::INS-1:0] status_clear_in,
  input wire logic [gpb_pkg::INS-1:0] route_smi_in,
  input wire logic [gpb_pkg::INS-1:0] route_sci_in,
  output logic [gpb_pkg::INS-1:0] input_event_status_out,
  output logic system_mgmt_interrupt_n_out,
  output logic power_event_interrupt_out
);
  import gpb_pkg::*;

  // ==========================================================================
  // State.
  typedef struct packed {
    logic [31:0] fsel;
    logic [31:0] dir;
    logic [31:0] lvl;
    logic [31:0] flash;
    logic [31:0] pol;
    logic [15:0] stat;
    logic [15:0] act_q;
    logic [31:0] rdata;
    logic rvalid;
    logic [31:0] pout;
    logic [31:0] poe;
    logic smi_n;
    logic power_event_interrupt;
    logic pair2;
    logic pair5;
  } gpb_state_type;

  localparam gpb_state_type STATE_RESET = '{
    fsel: FSEL_RESET,
    dir: DIR_RESET,
    lvl: LVL_RESET,
    flash: FLASH_RESET,
    pol: POL_RESET,
    stat: '0,
    act_q: '0,
    rdata: '0,
    rvalid: 1'b0,
    pout: '0,
    poe: '0,
    smi_n: 1'b1,
    power_event_interrupt: 1'b0,
    pair2: 1'b1,
    pair5: 1'b0
  };

  gpb_state_type s;
  gpb_state_type next_s;
  logic rst_n;
  logic host_ok;
  logic phase;
  logic [31:0] psync;

  // ==========================================================================
  // Reset release, pin synchronisers and the flash divider.
  gpb_sync #(.W(1)) u_rst_sync (
    .clk_in(mclk_in),
    .rst_n_in(nrst_in),
    .d_in(1'b1),
    .q_out(rst_n)
  );

  gpb_sync #(.W(1)) u_host_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .d_in(host_bus_reset_n_in),
    .q_out(host_ok)
  );

  gpb_sync #(.W(PINS)) u_pin_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .d_in(pin_in),
    .q_out(psync)
  );

  gpb_flash #(.HALF_CYCLES(FLASH_HALF_CYCLES)) u_flash (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .phase_out(phase)
  );

  // ==========================================================================
  // Derived views of the registers.
  logic [31:0] fsel_rd;
  logic [31:0] dir_rd;
  logic [31:0] lvl_rd;
  logic [31:0] gpio_mode;
  logic [31:0] gpio_oe;
  logic [31:0] wmask;
  logic [15:0] act;
  logic [15:0] set;

  always_comb begin
    // Unimplemented select bits read back their reset value.
    fsel_rd = (s.fsel & FSEL_IMPL) | (FSEL_RESET & ~FSEL_IMPL);
    dir_rd = (s.dir & DIR_WR) | DIR_RESET;
    // Output levels read back as stored, resume pins set as inputs read the pin.
    lvl_rd = (s.lvl & (LVL_CORE | (LVL_RES & ~dir_rd)))
      | (psync & LVL_RES & dir_rd);
    // A pin without a native partner has no select bit and is always
    // general purpose, whatever its select bit reads back.
    gpio_mode = (s.fsel & FSEL_IMPL) | ~FSEL_IMPL;
    // The grant pins follow the select bits of their request pins.
    gpio_mode[16] = fsel_rd[0];
    gpio_mode[17] = fsel_rd[1];
    gpio_oe = LVL_CORE | (LVL_RES & ~dir_rd);
    wmask = {{8{io_byte_en_in[3]}}, {8{io_byte_en_in[2]}},
      {8{io_byte_en_in[1]}}, {8{io_byte_en_in[0]}}};
    // Only the fixed inputs carry polarity.
    act = (psync[15:0] ^ s.pol[15:0]) & IN_IMPL;
    set = act & s.act_q;
  end

  function automatic logic [31:0] wr_field(
    input logic [31:0] cur,
    input logic [31:0] impl,
    input logic [31:0] data,
    input logic [31:0] be
  );
    wr_field = (cur & ~(be & impl)) | (data & be & impl);
  endfunction

  // ==========================================================================
  // Next state.
  always_comb begin
    next_s = s;
    next_s.rvalid = io_rd_in;
    next_s.rdata = '0;
    if (io_rd_in) begin
      case (io_addr_in)
        OFF_FSEL: next_s.rdata = fsel_rd;
        OFF_DIR: next_s.rdata = dir_rd;
        OFF_LVL: next_s.rdata = lvl_rd;
        OFF_DRV: next_s.rdata = DRV_RESET;
        OFF_FLASH: next_s.rdata = s.flash & FLASH_IMPL;
        OFF_POL: next_s.rdata = s.pol & POL_IMPL;
        default: next_s.rdata = '0;
      endcase
    end
    if (io_wr_in) begin
      case (io_addr_in)
        OFF_FSEL: next_s.fsel = wr_field(s.fsel, FSEL_IMPL,
          io_wdata_in, wmask);
        OFF_DIR: next_s.dir = wr_field(s.dir, DIR_WR,
          io_wdata_in, wmask);
        OFF_LVL: next_s.lvl = wr_field(s.lvl, LVL_CORE | LVL_RES,
          io_wdata_in, wmask);
        OFF_FLASH: next_s.flash = wr_field(s.flash, FLASH_IMPL,
          io_wdata_in, wmask);
        OFF_POL: next_s.pol = wr_field(s.pol, POL_IMPL,
          io_wdata_in, wmask);
        default: next_s.fsel = s.fsel;
      endcase
    end
    // A status event beats a clear in the same cycle.
    next_s.stat = ((s.stat & ~status_clear_in) | set) & IN_IMPL;
    next_s.act_q = act;
    next_s.smi_n = ~|(s.stat & route_smi_in);
    next_s.power_event_interrupt = |(s.stat & route_sci_in);
    next_s.pair5 = fsel_rd[PAIR_SEL_BIT] & general_control_bit25_in;
    next_s.pair2 = ~fsel_rd[PAIR_SEL_BIT];
    // Flashing substitutes the phase on the pin only.
    for (int p = 0; p < PINS; p++) begin
      if (gpio_mode[p]) begin
        next_s.poe[p] = gpio_oe[p] & PIN_EXIST[p];
        next_s.pout[p] = (s.flash[p] & FLASH_IMPL[p] & gpio_oe[p]) ?
          phase : s.lvl[p];
      end else begin
        next_s.poe[p] = native_oe_in[p] & PIN_EXIST[p];
        next_s.pout[p] = native_out_in[p];
      end
    end
    // Host bus reset returns only the core well bits.
    if (!host_ok) begin
      next_s.fsel = (next_s.fsel & ~FSEL_CORE) | (FSEL_RESET & FSEL_CORE);
      next_s.lvl = (next_s.lvl & ~LVL_CORE) | (LVL_RESET & LVL_CORE);
      next_s.flash = (next_s.flash & ~FLASH_CORE)
        | (FLASH_RESET & FLASH_CORE);
      next_s.pol = (next_s.pol & ~POL_CORE) | (POL_RESET & POL_CORE);
      next_s.stat = next_s.stat & ~STAT_CORE;
    end
  end

  // Outputs stay undriven through standby reset.
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign io_rdata_out = s.rdata;
  assign io_rvalid_out = s.rvalid;
  assign pin_out = s.pout;
  assign pin_oe_out = s.poe;
  assign req_pair2_en_out = s.pair2;
  assign req_pair5_en_out = s.pair5;
  assign input_event_status_out = s.stat;
  assign system_mgmt_interrupt_n_out = s.smi_n;
  assign power_event_interrupt_out = s.power_event_interrupt;

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n);

  a_status_sticky: assert property (
    ##1 (($past(s.stat) & ~$past(status_clear_in) & ~s.stat) == '0
      || !$past(host_ok)))
    else $error("Status bit dropped without a clear.");

  a_status_two_clk: assert property (
    ##2 ((s.stat & ~$past(s.stat) & ~($past(act, 2) & $past(act))) == '0))
    else $error("Status set without two active clocks.");

  a_dir_fixed: assert property (
    io_rd_in && io_addr_in == OFF_DIR |=> io_rdata_out[23:0] == 24'h00FFFF)
    else $error("Fixed direction bits read wrong.");

  a_fsel_absent: assert property (
    io_rd_in && io_addr_in == OFF_FSEL |=> io_rdata_out[31:29] == 3'h0)
    else $error("Absent select bits read nonzero.");

  a_level_kept: assert property (
    !io_wr_in && host_ok |=> s.lvl == $past(s.lvl))
    else $error("Level changed without a write.");

  a_flash_pin: assert property (
    s.flash[18] |=> pin_out[18] == $past(phase) && pin_oe_out[18])
    else $error("Flashing pin does not follow the phase.");

  a_input_no_drive: assert property (
    s.dir[25] |=> !pin_oe_out[25])
    else $error("Input pin is driven.");

  a_pair_five: assert property (
    s.fsel[1] && general_control_bit25_in |=> req_pair5_en_out
      && !req_pair2_en_out)
    else $error("Pair five not selected.");

  a_smi_route: assert property (
    |(s.stat & route_smi_in) |=> !system_mgmt_interrupt_n_out)
    else $error("Routed status did not raise the interrupt.");

  a_native_pin: assert property (
    !s.fsel[0] |=> pin_out[16] == $past(native_out_in[16]))
    else $error("Native pin not passed through.");

  a_pair_two: assert property (
    !s.fsel[PAIR_SEL_BIT] |=> req_pair2_en_out && !req_pair5_en_out)
    else $error("Pair two not kept while the select bit is clear.");

  a_sci_route: assert property (
    |(s.stat & route_sci_in) |=> power_event_interrupt_out)
    else $error("Routed status did not raise the event interrupt.");

  a_level_drive: assert property (
    !s.dir[25] && !s.flash[25] |=> pin_oe_out[25]
      && pin_out[25] == $past(s.lvl[25]))
    else $error("Output pin does not drive its level bit.");

  a_core_reset: assert property (
    !host_ok |=> (s.lvl & LVL_CORE) == (LVL_RESET & LVL_CORE))
    else $error("Core level bits not reset by the host reset.");

  a_resume_kept: assert property (
    !host_ok && !io_wr_in |=> (s.lvl & LVL_RES) == ($past(s.lvl) & LVL_RES))
    else $error("Resume level bits changed by the host reset.");

  a_pol_absent: assert property (
    io_rd_in && io_addr_in == OFF_POL |=> io_rdata_out[31:14] == 18'h0)
    else $error("Absent polarity bits read nonzero.");

  c_flash_toggle: cover property (s.flash[18] ##1 $changed(pin_out[18]));
  c_status_set: cover property ($rose(s.stat[7]));
  c_pair_five: cover property ($rose(req_pair5_en_out));
  c_level_read: cover property (io_rd_in && io_addr_in == OFF_LVL);
  c_host_reset: cover property ($rose(host_ok));
endmodule

// file: test/gpb_board.sv
// Board model: pin resolution and the native function logic.
module gpb_board (
  input wire logic [31:0] pin_out_in,
  input wire logic [31:0] pin_oe_in,
  input wire logic [31:0] ext_level_in,
  input wire logic [31:0] native_drive_in,
  output logic [31:0] pin_level_out,
  output logic [31:0] native_out_out,
  output logic [31:0] native_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released pin takes the board level, never the last driven value.
  assign pin_level_out = (pin_oe_in & pin_out_in)
    | (~pin_oe_in & ext_level_in);
  assign native_out_out = native_drive_in;
  // Native logic drives the grant side only.
  assign native_oe_out = 32'h00FF0000;
endmodule

// file: test/gpb_bank_bench.sv
// Self-checking bench for the GPIO bank.
module gpb_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import gpb_pkg::*;
  localparam int HALF = 8;
  logic mclk = 1'b0;
  logic nrst, hrst_n, io_wr, io_rd, rvalid, gc25, pair2, pair5, smi_n, power_event_interrupt;
  logic prev;
  logic [5:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, pin_lvl, pout, poe, ext, nat_drv, nat_out, nat_oe;
  logic [15:0] clr, rsmi, rsci, sts;
  int error_cnt, tests_run, n;
  logic [5:0] offs [7] = '{6'h00, 6'h04, 6'h0C, 6'h14, 6'h18, 6'h2C,
    6'h08};
  logic [31:0] rstv [7] = '{32'h1A003180, 32'h0000FFFF, 32'h1B3F0000,
    32'h06630000, 32'h00040000, 32'h00000000, 32'h00000000};
  always #10 mclk = ~mclk;
  gpb_bank #(.FLASH_HALF_CYCLES(HALF)) u_dut (.mclk_in(mclk), .nrst_in(nrst),
    .host_bus_reset_n_in(hrst_n), .io_addr_in(addr), .io_wr_in(io_wr),
    .io_rd_in(io_rd), .io_byte_en_in(be), .io_wdata_in(wdata),
    .io_rdata_out(rdata), .io_rvalid_out(rvalid), .pin_in(pin_lvl),
    .pin_out(pout), .pin_oe_out(poe), .native_out_in(nat_out),
    .native_oe_in(nat_oe), .general_control_bit25_in(gc25),
    .req_pair2_en_out(pair2), .req_pair5_en_out(pair5),
    .status_clear_in(clr), .route_smi_in(rsmi), .route_sci_in(rsci),
    .input_event_status_out(sts), .system_mgmt_interrupt_n_out(smi_n),
    .power_event_interrupt_out(power_event_interrupt));
  gpb_board u_board (.pin_out_in(pout), .pin_oe_in(poe), .ext_level_in(ext),
    .native_drive_in(nat_drv), .pin_level_out(pin_lvl),
    .native_out_out(nat_out), .native_oe_out(nat_oe));
  // ==========================================================================
  // Access and comparison tasks.
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] b);
    tick(1);
    addr = a;
    wdata = d;
    be = b;
    io_wr = 1'b1;
    tick(1);
    io_wr = 1'b0;
  endtask
  task rd(input string nm, input logic [5:0] a, input logic [31:0] e);
    tick(1);
    addr = a;
    io_rd = 1'b1;
    tick(1);
    io_rd = 1'b0;
    chk({nm, " valid"}, 32'h1, {31'h0, rvalid});
    chk(nm, e, rdata);
  endtask
  task print_verdict;
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================================
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    #(20 * 4000);
    error_cnt++;
    print_verdict();
  end
  // ==========================================================================
  // Test sequence.
  initial begin
    {nrst, hrst_n, io_wr, io_rd, gc25, addr, be, wdata} = '0;
    {ext, clr, rsmi, rsci} = '0;
    nat_drv = 32'h00010000;
    repeat (12) @(posedge mclk);
    #1;
    chk("reset drive", 32'h0, poe | pout);
    nrst = 1'b1;
    hrst_n = 1'b1;
    tick(6);
    for (int i = 0; i < 7; i++) begin
      rd("reset", offs[i], rstv[i]);
    end
    chk("native pins", 32'h1, {30'h0, pout[17:16]});
    chk("native oe", 32'h3, {30'h0, poe[17:16]});
    nat_drv = 32'h00020000;
    tick(3);
    chk("native follow", 32'h2, {30'h0, pout[17:16]});
    chk("pair2 reset", 32'h1, {31'h0, pair2});
    $display("Test reset done");
    gc25 = 1'b1;
    wr(6'h00, 32'hFFFFFFFF, 4'hF);
    rd("select", 6'h00, 32'h1A20399B);
    chk("pair2", 32'h0, {31'h0, pair2});
    chk("pair5", 32'h1, {31'h0, pair5});
    wr(6'h0C, 32'h0, 4'hF);
    rd("level", 6'h0C, 32'h0);
    tick(2);
    chk("out oe", 32'h1BFF0000, poe & 32'h1BFF0000);
    chk("out level", 32'h0, pout & 32'h1BFB0000);
    wr(6'h2C, 32'hFFFFFFFF, 4'h1);
    rd("polarity byte", 6'h2C, 32'h000000DB);
    wr(6'h2C, 32'hFFFFFFFF, 4'hF);
    rd("polarity", 6'h2C, 32'h000039DB);
    $display("Test select done");
    hrst_n = 1'b0;
    tick(6);
    hrst_n = 1'b1;
    tick(4);
    rd("level host", 6'h0C, 32'h003F0000);
    rd("polarity host", 6'h2C, 32'h00003900);
    chk("resume out", 32'h0, pout & 32'h1B000000);
    $display("Test host reset done");
    wr(6'h04, 32'hFFFFFFFF, 4'hF);
    rd("direction", 6'h04, 32'h1B00FFFF);
    ext = 32'h09000000;
    tick(4);
    chk("input oe", 32'h0, poe & 32'h1B000000);
    rd("level input", 6'h0C, 32'h093F0000);
    wr(6'h14, 32'hFFFFFFFF, 4'hF);
    rd("driver type", 6'h14, 32'h06630000);
    wr(6'h08, 32'hFFFFFFFF, 4'hF);
    rd("unmapped", 6'h08, 32'h0);
    $display("Test direction done");
    n = 0;
    prev = pout[18];
    repeat (64) begin
      tick(1);
      if (pout[18] !== prev) n++;
      prev = pout[18];
    end
    chk("flash toggles", 32'd8, n);
    rd("level kept", 6'h0C, 32'h093F0000);
    wr(6'h18, 32'h02000000, 4'hF);
    tick(20);
    chk("flash input", 32'h0, {31'h0, poe[25]});
    tick(3);
    chk("flash off", 32'h1, {31'h0, pout[18]});
    $display("Test flash done");
    wr(6'h2C, 32'h0, 4'hF);
    ext = 32'h0;
    clr = 16'hFFFF;
    tick(1);
    clr = 16'h0;
    tick(3);
    ext[8] = 1'b1;
    tick(1);
    ext[8] = 1'b0;
    tick(6);
    chk("short pulse", 32'h0, sts);
    ext[7] = 1'b1;
    tick(2);
    ext[7] = 1'b0;
    tick(6);
    chk("sticky", 32'h0080, sts);
    rsmi = 16'h0080;
    tick(3);
    chk("smi", 32'h0, {31'h0, smi_n});
    rsmi = 16'h0;
    rsci = 16'h0080;
    tick(3);
    chk("sci", 32'h1, {31'h0, power_event_interrupt});
    clr = 16'h0080;
    tick(1);
    clr = 16'h0;
    tick(3);
    chk("cleared", 32'h0, {15'h0, power_event_interrupt, sts});
    wr(6'h2C, 32'h00001000, 4'hF);
    tick(8);
    chk("low active", 32'h1000, sts);
    $display("Test events done");
    print_verdict();
  end
endmodule
